// *** verilog/e3rx_pkg.sv ***
package e3rx_pkg;

	// ********************************
	// Register byte addresses
	// ********************************
	localparam logic [11:0] IRQ_EN_B_ADDR  = 12'h12E;
	localparam logic [11:0] MA_STATUS_ADDR = 12'h130;
	localparam logic [11:0] NR_GC_ADDR     = 12'h132;
	localparam logic [11:0] FE_COUNT_ADDR  = 12'h134;
	localparam logic [11:0] STATUS_ADDR    = 12'h138;
	localparam logic [11:0] GLOBAL_EN_ADDR = 12'h13C;
	localparam logic [11:0] CONFIG_ADDR    = 12'h140;

	// ********************************
	// Field positions
	// ********************************
	localparam int FE_BIT       = 8;
	localparam int REM_CNT_BIT  = 2;
	localparam int PAR_CNT_BIT  = 1;
	localparam int FE_CNT_BIT   = 0;
	localparam int RPT_LSB      = 4;
	localparam int TI_MSB       = 3;
	localparam int GC_LSB       = 8;
	localparam int PORT_EN_LSB  = 1;
	localparam int TI_EXT_BIT   = 0;

	// ********************************
	// Reset values and masks
	// ********************************
	localparam logic [15:0] REG_RESET   = 16'h0000;
	localparam logic [15:0] EVENT_MASK  = 16'h0107;
	localparam logic [3:0]  GLOBAL_MASK = 4'hF;

endpackage

// *** verilog/e3rx_evt_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface e3rx_evt_if;
	logic        frame_err;
	logic        remote_cnt_nz;
	logic        parity_cnt_nz;
	logic        frame_cnt_nz;
	logic [15:0] set_vec;

	modport src (input frame_err, input remote_cnt_nz, input parity_cnt_nz,
		input frame_cnt_nz, output set_vec);
	modport dst (input set_vec);
endinterface

`default_nettype wire

// *** verilog/e3rx_evt_detect.sv ***
`timescale 1ns/1ps
`default_nettype none

module e3rx_evt_detect (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Events
	e3rx_evt_if.src   evt
);

	logic [2:0] cnt_nz_r;
	logic [2:0] cnt_nz_now;
	logic [2:0] cnt_rise;

	assign cnt_nz_now = {evt.remote_cnt_nz, evt.parity_cnt_nz, evt.frame_cnt_nz};
	assign cnt_rise   = cnt_nz_now & ~cnt_nz_r;

	always_comb begin
		evt.set_vec                       = e3rx_pkg::REG_RESET;
		evt.set_vec[e3rx_pkg::FE_BIT]     = evt.frame_err;
		evt.set_vec[e3rx_pkg::REM_CNT_BIT] = cnt_rise[2];
		evt.set_vec[e3rx_pkg::PAR_CNT_BIT] = cnt_rise[1];
		evt.set_vec[e3rx_pkg::FE_CNT_BIT]  = cnt_rise[0];
	end

	// Nonzero flags start at zero so a count present at reset raises a flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_nz_r <= 3'h0;
		end else begin
			cnt_nz_r <= cnt_nz_now;
		end
	end

endmodule

`default_nettype wire

// *** verilog/e3rx_wb_slave.sv ***
`timescale 1ns/1ps
`default_nettype none

module e3rx_wb_slave (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone handshake
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic             ack_o,
	output logic             acc_o
);

	// One wait state, ack dropped after one cycle so back-to-back holds stay clean
	assign acc_o = cyc_i & stb_i & ~ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= acc_o;
		end
	end

endmodule

`default_nettype wire

// *** verilog/e3rx_regs.sv ***
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Frame error irq needs bit8, flag, port enable
// - Remote count irq needs bit2 and port enable
// - Parity count irq needs bit1 and port enable
// - Frame count irq needs bit0 and port enable
// - Enable zero disables, one enables
// - Payload type in MA bits 6:4
// - Extraction on: four timing bits 3:0
// - Extraction off: bit3 zero, three bits
// - GC byte in bits 15:8, reset zero
// - NR byte in bits 7:0, reset zero
// - Framing error sets frame error flag
// - Count flags set on nonzero rising
module e3rx_regs #(
	parameter int PORT_IDX = 0
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [11:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Receive overhead
	input  wire logic        frame_err_i,
	input  wire logic        remote_cnt_nz_i,
	input  wire logic        parity_cnt_nz_i,
	input  wire logic        frame_cnt_nz_i,
	input  wire logic        ma_valid_i,
	input  wire logic [7:0]  ma_byte_i,
	input  wire logic        ti_word_valid_i,
	input  wire logic [3:0]  ti_word_i,
	input  wire logic        nr_gc_valid_i,
	input  wire logic [7:0]  nr_byte_i,
	input  wire logic [7:0]  gc_byte_i,
	input  wire logic [15:0] frame_err_count_i,
	// Interrupt
	output logic             irq_o
);

	// ********************************
	// Storage
	// ********************************
	logic [15:0] irq_en_r;
	logic [15:0] status_r;
	logic [15:0] status_nxt;
	logic [15:0] ma_status_r;
	logic [15:0] nr_gc_r;
	logic [3:0]  global_en_r;
	logic        ti_ext_r;
	logic [31:0] dat_nxt;
	logic        irq_nxt;

	// ********************************
	// Bus front end
	// ********************************
	logic acc;

	e3rx_wb_slave u_wb (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cyc_i (cyc_i),
		.stb_i (stb_i),
		.ack_o (ack_o),
		.acc_o (acc)
	);

	function automatic logic [15:0] lane_mask(input logic [3:0] sel);
		return {{8{sel[1]}}, {8{sel[0]}}};
	endfunction

	wire        wr        = acc & we_i;
	wire [15:0] wmask     = lane_mask(sel_i);
	wire [15:0] wdata     = dat_i[15:0] & wmask;
	wire        wr_en     = wr & (adr_i == e3rx_pkg::IRQ_EN_B_ADDR);
	wire        wr_status = wr & (adr_i == e3rx_pkg::STATUS_ADDR);
	wire        wr_global = wr & (adr_i == e3rx_pkg::GLOBAL_EN_ADDR);
	wire        wr_config = wr & (adr_i == e3rx_pkg::CONFIG_ADDR);

	// ********************************
	// Event detection
	// ********************************
	e3rx_evt_if evt_bus ();

	assign evt_bus.frame_err     = frame_err_i;
	assign evt_bus.remote_cnt_nz = remote_cnt_nz_i;
	assign evt_bus.parity_cnt_nz = parity_cnt_nz_i;
	assign evt_bus.frame_cnt_nz  = frame_cnt_nz_i;

	e3rx_evt_detect u_evt (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.evt   (evt_bus)
	);

	// Set beats write-one-to-clear in the same cycle
	assign status_nxt = (status_r & ~(wr_status ? wdata : e3rx_pkg::REG_RESET))
		| evt_bus.set_vec;

	// ********************************
	// Interrupt combine
	// ********************************
	wire        port_en = global_en_r[PORT_IDX];
	wire [15:0] active  = status_r & irq_en_r;
	assign irq_nxt = port_en & (|active);

	// ********************************
	// Received overhead capture
	// ********************************
	// MA byte numbered 1..8 from msb: MA[3:5] is ma_byte_i[5:3]
	wire [2:0]  rpt_in  = ma_byte_i[5:3];
	wire [3:0]  ti_in   = ti_ext_r ? ti_word_i : {1'b0, ma_byte_i[2:0]};
	wire        ti_load = ti_ext_r ? ti_word_valid_i : ma_valid_i;

	// ********************************
	// Read mux
	// ********************************
	always_comb begin
		dat_nxt = 32'h0000_0000;
		case (adr_i)
			e3rx_pkg::IRQ_EN_B_ADDR:  dat_nxt[15:0] = irq_en_r;
			e3rx_pkg::MA_STATUS_ADDR: dat_nxt[15:0] = ma_status_r;
			e3rx_pkg::NR_GC_ADDR:     dat_nxt[15:0] = nr_gc_r;
			e3rx_pkg::FE_COUNT_ADDR:  dat_nxt[15:0] = frame_err_count_i;
			e3rx_pkg::STATUS_ADDR:    dat_nxt[15:0] = status_r;
			e3rx_pkg::GLOBAL_EN_ADDR:
				dat_nxt[e3rx_pkg::PORT_EN_LSB +: 4] = global_en_r;
			e3rx_pkg::CONFIG_ADDR:    dat_nxt[e3rx_pkg::TI_EXT_BIT] = ti_ext_r;
			default:                  dat_nxt = 32'h0000_0000;
		endcase
	end

	// ********************************
	// Registers
	// ********************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_en_r <= e3rx_pkg::REG_RESET;
		end else if (wr_en) begin
			irq_en_r <= (irq_en_r & ~wmask) | (wdata & e3rx_pkg::EVENT_MASK);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_r <= e3rx_pkg::REG_RESET;
		end else begin
			status_r <= status_nxt & e3rx_pkg::EVENT_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			global_en_r <= 4'h0;
			ti_ext_r    <= 1'b0;
		end else begin
			if (wr_global && sel_i[0]) begin
				global_en_r <= dat_i[e3rx_pkg::PORT_EN_LSB +: 4] & e3rx_pkg::GLOBAL_MASK;
			end
			if (wr_config && sel_i[0]) begin
				ti_ext_r <= dat_i[e3rx_pkg::TI_EXT_BIT];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ma_status_r <= e3rx_pkg::REG_RESET;
		end else begin
			if (ma_valid_i) begin
				ma_status_r[e3rx_pkg::RPT_LSB +: 3] <= rpt_in;
			end
			if (ti_load) begin
				ma_status_r[e3rx_pkg::TI_MSB:0] <= ti_in;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nr_gc_r <= e3rx_pkg::REG_RESET;
		end else if (nr_gc_valid_i) begin
			nr_gc_r <= {gc_byte_i, nr_byte_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
			irq_o <= 1'b0;
		end else begin
			dat_o <= acc ? dat_nxt : 32'h0000_0000;
			irq_o <= irq_nxt;
		end
	end

endmodule

`default_nettype wire

// *** sim/e3rx_props.sv ***
`timescale 1ns/1ps
`default_nettype none

module e3rx_props (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Bus
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	// Events and interrupt
	input wire logic        frame_err_i,
	input wire logic        remote_cnt_nz_i,
	input wire logic        parity_cnt_nz_i,
	input wire logic        frame_cnt_nz_i,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_ack_one_cycle: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_ack_wait_state: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack late");
	chk_ack_has_request: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	chk_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");
	chk_upper_half_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0)
		else $error("upper read half not zero");
	chk_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !irq_o)
		else $error("outputs not quiet after reset");
	// Rise needs an event at its fixed depth or an enable write
	chk_irq_rise_cause: assert property ($rose(irq_o) |-> $past(ack_o && we_i)
		|| $past(frame_err_i, 2) || $past(remote_cnt_nz_i, 2)
		|| $past(parity_cnt_nz_i, 2) || $past(frame_cnt_nz_i, 2))
		else $error("irq rose without cause");
	chk_irq_fall_cause: assert property ($fell(irq_o) && !$past(rst_i) |->
		$past(ack_o && we_i)) else $error("irq fell without write");
endmodule

bind e3rx_regs e3rx_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .frame_err_i(frame_err_i),
	.remote_cnt_nz_i(remote_cnt_nz_i), .parity_cnt_nz_i(parity_cnt_nz_i),
	.frame_cnt_nz_i(frame_cnt_nz_i), .irq_o(irq_o));

`default_nettype wire

// *** sim/tb_e3_rx_overhead_status_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_e3_rx_overhead_status_regs;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, ma_v, ti_v, ng_v;
	logic [11:0] adr_i;
	logic [31:0] dat_i, dat_o, rd;
	logic [7:0]  ma, nr, gc;
	logic [3:0]  ev, ti;
	int          failures, n_compared, cyc_n;

	e3rx_regs #(.PORT_IDX(0)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h3), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .frame_err_i(ev[3]), .remote_cnt_nz_i(ev[2]),
		.parity_cnt_nz_i(ev[1]), .frame_cnt_nz_i(ev[0]), .ma_valid_i(ma_v),
		.ma_byte_i(ma), .ti_word_valid_i(ti_v), .ti_word_i(ti), .nr_gc_valid_i(ng_v),
		.nr_byte_i(nr), .gc_byte_i(gc), .frame_err_count_i(16'h1234), .irq_o(irq_o));

	// ****
	// Bus and checking
	// ****
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic t_regs;
		wb(1'b0, 12'h12E, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, 12'h132, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, 12'h130, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, 12'h134, 32'h0);
		chk(rd, 32'h1234);
		wb(1'b1, 12'h12E, 32'hFFFF);
		wb(1'b0, 12'h12E, 32'h0);
		chk(rd, 32'h0107);
		wb(1'b1, 12'h200, 32'hFFFF);
		wb(1'b0, 12'h200, 32'h0);
		chk(rd, 32'h0);
	endtask

	task automatic t_irq;
		logic [15:0] b;
		wb(1'b1, 12'h13C, 32'h2);
		for (int i = 3; i >= 0; i--) begin
			b = (i == 3) ? 16'h0100 : 16'h0001 << i;
			wb(1'b1, 12'h12E, {16'h0, b});
			ev <= 4'h1 << i;
			@(posedge clk_i);
			ev <= 4'h0;
			repeat (4) @(posedge clk_i);
			chk(irq_o, 1'b1);
			wb(1'b0, 12'h138, 32'h0);
			chk(rd, {16'h0, b});
			wb(1'b1, 12'h13C, 32'h0);
			chk(irq_o, 1'b0);
			wb(1'b1, 12'h13C, 32'h2);
			wb(1'b1, 12'h12E, 32'h0);
			chk(irq_o, 1'b0);
			wb(1'b1, 12'h12E, {16'h0, b});
			chk(irq_o, 1'b1);
			wb(1'b1, 12'h138, {16'h0, b});
			chk(irq_o, 1'b0);
		end
	endtask

	// MA bits run msb first, so B5 gives type 6 and low bits 5
	task automatic t_ovh;
		wb(1'b1, 12'h140, 32'h1);
		ma <= 8'hB5;
		ti <= 4'hA;
		nr <= 8'h3C;
		gc <= 8'hA5;
		ma_v <= 1'b1;
		ti_v <= 1'b1;
		ng_v <= 1'b1;
		@(posedge clk_i);
		{ma_v, ti_v, ng_v} <= 3'h0;
		wb(1'b0, 12'h130, 32'h0);
		chk(rd, 32'h6A);
		wb(1'b0, 12'h132, 32'h0);
		chk(rd, 32'hA53C);
		wb(1'b1, 12'h140, 32'h0);
		ma_v <= 1'b1;
		@(posedge clk_i);
		ma_v <= 1'b0;
		wb(1'b0, 12'h130, 32'h0);
		chk(rd, 32'h65);
	endtask

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Ceiling well above the roughly 160 cycles the run needs
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			failures++;
			close_out;
		end
	end

	initial begin
		{cyc_i, stb_i, we_i, ma_v, ti_v, ng_v, adr_i, dat_i} = '0;
		{ma, nr, gc, ev, ti} = '0;
		rst_i = 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs;
		t_irq;
		t_ovh;
		close_out;
	end
endmodule

`default_nettype wire
